// >>> verilog/opd_pkg.sv
// constants and types shared by the operand decode and add path
package opd_pkg;

  // operations the core executes
  typedef enum logic [3:0] {
    OPD_ADD_A_IMM,
    OPD_ADD_SADDR_IMM,
    OPD_ADD_A_R,
    OPD_ADD_R_A,
    OPD_ADD_A_SADDR,
    OPD_ADD_A_ABS,
    OPD_BRANCH_REL,
    OPD_SET_ABIT,
    OPD_SEL_BANK,
    OPD_RESTORE_FLAGS
  } opd_op_e;

  // address operand forms checked by the range decoder
  typedef enum logic [2:0] {
    OPD_AM_SADDR,
    OPD_AM_SADDRP,
    OPD_AM_SFR,
    OPD_AM_SFRP,
    OPD_AM_ABS,
    OPD_AM_ABS_WORD,
    OPD_AM_ELEVEN,
    OPD_AM_TABLE
  } opd_amode_e;

  typedef enum logic {
    OPD_IDLE,
    OPD_EXEC
  } opd_state_e;

  // address windows of the operand forms
  localparam logic [15:0] SADDR_LO = 16'hFE20;
  localparam logic [15:0] SADDR_HI = 16'hFF1F;
  localparam logic [15:0] SFR_LO = 16'hFF00;
  localparam logic [15:0] HOLE_LO = 16'hFFD0;
  localparam logic [15:0] HOLE_HI = 16'hFFDF;
  localparam logic [15:0] ELEVEN_LO = 16'h0800;
  localparam logic [15:0] ELEVEN_HI = 16'h0FFF;
  localparam logic [15:0] TABLE_LO = 16'h0040;
  localparam logic [15:0] TABLE_HI = 16'h007F;

  // processor flags layout and value after reset
  localparam int FLG_CY = 0;
  localparam int FLG_NMI = 2;
  localparam int FLG_BANK_LO = 3;
  localparam int FLG_AC = 4;
  localparam int FLG_BANK_HI = 5;
  localparam int FLG_Z = 6;
  localparam int FLG_IE = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;

  // single register codes used directly by the datapath
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;

  // instruction clock counts, short form and long form
  localparam logic [3:0] CYC_ADD_A_IMM = 4'h4;
  localparam logic [3:0] CYC_ADD_SADDR_IMM_S = 4'h6;
  localparam logic [3:0] CYC_ADD_SADDR_IMM_L = 4'h8;
  localparam logic [3:0] CYC_ADD_A_R = 4'h4;
  localparam logic [3:0] CYC_ADD_A_SADDR_S = 4'h4;
  localparam logic [3:0] CYC_ADD_A_SADDR_L = 4'h5;
  localparam logic [3:0] CYC_ADD_A_ABS_S = 4'h8;
  localparam logic [3:0] CYC_ADD_A_ABS_L = 4'h9;
  localparam logic [3:0] CYC_BRANCH = 4'h6;
  localparam logic [3:0] CYC_SET_ABIT = 4'h4;
  localparam logic [3:0] CYC_SEL_BANK = 4'h4;
  localparam logic [3:0] CYC_RESTORE = 4'h6;

endpackage

// >>> verilog/opd_adder8.sv
// 8-bit adder with carry in, carry out, half carry and zero
`timescale 1ns/1ps
module opd_adder8
  import opd_pkg::*;
(
  input wire logic [7:0] x, // first operand
  input wire logic [7:0] y, // second operand
  input wire logic cin, // incoming carry
  output logic [7:0] sum, // 8-bit result
  output logic cout, // carry out of bit 7
  output logic half, // carry out of bit 3
  output logic zero // result is zero
);

  logic [8:0] full;
  logic [4:0] low;

  // full and low-nibble sums share the same carry in
  always_comb
  begin
    full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    low = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    sum = full[7:0];
    cout = full[8];
    half = low[4]; // see (RQ21)
    zero = (full[7:0] == 8'h00); // see (RQ21)
  end

endmodule

// >>> verilog/opd_core.sv
// operand decode, timing and 8-bit add path of the core
//
// Operation
// (RQ1) One instruction clock equals one clk period of the selected CPU clock.
// (RQ2) Short clock count for high-speed RAM access or no data access.
// (RQ3) Long clock count for data access outside high-speed RAM.
// (RQ4) Register field 0..7 maps to X, A, C, B, E, D, L, H.
// (RQ5) Pair field 0..3 maps to AX, BC, DE, HL.
// (RQ6) Short direct reaches FE20H-FF1FH only; word form even only.
// (RQ7) Special and short direct forms never reach FFD0H-FFDFH.
// (RQ8) Word special form needs word-capable register at even address.
// (RQ9) Absolute operand spans whole space; even only for word transfers.
// (RQ10) Eleven-bit target lies within 0800H-0FFFH.
// (RQ11) Table slot target is even within 0040H-007FH.
// (RQ12) Branch displacement is signed 8-bit added to the program counter.
// (RQ13) Bit operand is a 3-bit field picking one of eight bits.
// (RQ14) Flags hold a bank select field choosing one of four banks.
// (RQ15) Flags hold interrupt enable and non-maskable in-service flags.
// (RQ16) Each flag is kept, cleared, set, computed or restored per op.
// (RQ17) A is the byte accumulator; X and A form the word accumulator.
// (RQ18) Add immediate to A takes 4 clocks, writes sum and flags.
// (RQ19) Add with carry adds the carry flag into the sum.
// (RQ20) Add immediate to short direct writes memory, 6 or 8 clocks.
// (RQ21) Zero flag on zero result, half carry on carry out of bit 3.
// (RQ22) Register-to-A add naming A itself is refused.
`timescale 1ns/1ps
module opd_core
  import opd_pkg::*;
#(
  parameter logic [15:0] HSRAM_LO = 16'hFB00, // fast RAM lowest address
  parameter logic [15:0] HSRAM_HI = 16'hFEFF // fast RAM highest address
)
(
  input wire logic clk, // cpu clock
  input wire logic arst_n, // async reset, active low
  input wire logic start, // request to execute op
  input wire opd_op_e op, // operation
  input wire logic use_carry, // add with carry
  input wire logic [2:0] reg_sel, // single register field
  input wire logic [1:0] pair_sel, // register pair field
  input wire logic [7:0] imm, // immediate byte
  input wire logic [7:0] mem_rdata, // memory operand byte
  input wire logic [15:0] addr, // data or checked address
  input wire opd_amode_e amode, // form for address check
  input wire logic sfr_word_ok, // sfr at addr is word capable
  input wire logic [7:0] disp, // branch displacement
  input wire logic [15:0] pc, // program counter of the op
  input wire logic [2:0] bit_sel, // bit position field
  input wire logic nmi_take, // nmi service begins
  input wire logic nmi_return, // nmi service ends
  output logic busy, // op in progress
  output logic done, // op finished, one cycle
  output logic fault, // op refused, one cycle
  output logic long_timing, // current op uses long count
  output logic addr_ok, // addr legal for amode
  output logic mem_wr, // memory write strobe
  output logic [15:0] mem_waddr, // memory write address
  output logic [7:0] mem_wdata, // memory write data
  output logic [15:0] branch_target, // relative branch target
  output logic [7:0] acc, // byte accumulator
  output logic [15:0] word_accumulator, // X and A pair
  output logic [15:0] pair_value, // pair chosen by pair_sel
  output logic [7:0] processor_flags, // full flag byte
  output logic carry_flag, // carry
  output logic half_carry_flag, // half carry
  output logic zero_flag, // zero
  output logic [1:0] bank_select_field, // active bank
  output logic irq_enable_flag, // maskable irq enable
  output logic nmi_in_service_flag // nmi being serviced
);

  logic [1:0] rst_pipe_ff;
  logic rst_n;
  opd_state_e state_ff;
  logic [3:0] cnt_ff;
  opd_op_e op_ff;
  logic [4:0] dst_ff;
  logic [7:0] res_ff;
  logic cy_ff;
  logic ac_ff;
  logic z_ff;
  logic [7:0] flags_ff;
  logic [7:0] regs_ff [0:31];
  logic busy_ff;
  logic done_ff;
  logic fault_ff;
  logic long_ff;
  logic addr_ok_ff;
  logic mem_wr_ff;
  logic [15:0] mem_waddr_ff;
  logic [7:0] mem_wdata_ff;
  logic [15:0] target_ff;
  logic [7:0] acc_ff;
  logic [15:0] wacc_ff;
  logic [15:0] pair_ff;
  logic [1:0] bank;
  logic [7:0] cur_a;
  logic [7:0] cur_r;
  logic [7:0] add_x;
  logic [7:0] add_y;
  logic [7:0] sum;
  logic cout;
  logic half;
  logic zero;
  logic refuse;
  logic go;
  logic commit;
  logic is_add;
  logic access;
  logic nxt_long;
  logic [3:0] nxt_cyc;

  // address range check for every operand form
  function automatic logic addr_legal(opd_amode_e m, logic [15:0] a,
                                      logic word_ok);
    logic in_hole;
    logic in_saddr;
    in_hole = (a >= HOLE_LO) && (a <= HOLE_HI); // see (RQ7)
    in_saddr = (a >= SADDR_LO) && (a <= SADDR_HI); // see (RQ6)
    case (m)
      OPD_AM_SADDR: addr_legal = in_saddr && !in_hole;
      OPD_AM_SADDRP: addr_legal = in_saddr && !in_hole && !a[0];
      OPD_AM_SFR: addr_legal = (a >= SFR_LO) && !in_hole; // see (RQ7)
      OPD_AM_SFRP: addr_legal = (a >= SFR_LO) && !in_hole && !a[0]
                                && word_ok; // see (RQ8)
      OPD_AM_ABS: addr_legal = 1'b1; // see (RQ9)
      OPD_AM_ABS_WORD: addr_legal = !a[0]; // see (RQ9)
      OPD_AM_ELEVEN: addr_legal = (a >= ELEVEN_LO)
                                  && (a <= ELEVEN_HI); // see (RQ10)
      OPD_AM_TABLE: addr_legal = (a >= TABLE_LO) && (a <= TABLE_HI)
                                 && !a[0]; // see (RQ11)
      default: addr_legal = 1'b0;
    endcase
  endfunction

  // fast RAM area decides the short clock count
  function automatic logic in_hsram(logic [15:0] a);
    in_hsram = (a >= HSRAM_LO) && (a <= HSRAM_HI);
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_pipe_ff <= 2'h0;
    else
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
  end

  assign rst_n = rst_pipe_ff[1];

  // operand selection from the active bank
  always_comb
  begin
    bank = {flags_ff[FLG_BANK_HI], flags_ff[FLG_BANK_LO]}; // see (RQ14)
    cur_a = regs_ff[{bank, REG_A}]; // see (RQ17)
    cur_r = regs_ff[{bank, reg_sel}]; // see (RQ4)
    add_x = cur_a;
    add_y = mem_rdata;
    if (op == OPD_ADD_A_IMM)
      add_y = imm;
    else if (op == OPD_ADD_SADDR_IMM)
    begin
      add_x = mem_rdata;
      add_y = imm;
    end
    else if ((op == OPD_ADD_A_R) || (op == OPD_ADD_R_A))
      add_y = cur_r;
  end

  opd_adder8 u_adder (
    .x(add_x),
    .y(add_y),
    .cin(use_carry & flags_ff[FLG_CY]), // see (RQ19)
    .sum(sum),
    .cout(cout),
    .half(half),
    .zero(zero)
  );

  // decode of timing, refusal and acceptance
  always_comb
  begin
    is_add = (op == OPD_ADD_A_IMM) || (op == OPD_ADD_SADDR_IMM)
             || (op == OPD_ADD_A_R) || (op == OPD_ADD_R_A)
             || (op == OPD_ADD_A_SADDR) || (op == OPD_ADD_A_ABS);
    access = (op == OPD_ADD_SADDR_IMM) || (op == OPD_ADD_A_SADDR)
             || (op == OPD_ADD_A_ABS);
    nxt_long = access && !in_hsram(addr); // see (RQ2) (RQ3)
    refuse = ((op == OPD_ADD_A_R) && (reg_sel == REG_A)) // see (RQ22)
             || (((op == OPD_ADD_SADDR_IMM) || (op == OPD_ADD_A_SADDR))
                 && !addr_legal(OPD_AM_SADDR, addr, 1'b0)); // see (RQ6)
    case (op)
      OPD_ADD_A_IMM: nxt_cyc = CYC_ADD_A_IMM; // see (RQ18)
      OPD_ADD_SADDR_IMM: nxt_cyc = nxt_long ? CYC_ADD_SADDR_IMM_L
                                            : CYC_ADD_SADDR_IMM_S;
      OPD_ADD_A_R: nxt_cyc = CYC_ADD_A_R;
      OPD_ADD_R_A: nxt_cyc = CYC_ADD_A_R;
      OPD_ADD_A_SADDR: nxt_cyc = nxt_long ? CYC_ADD_A_SADDR_L
                                          : CYC_ADD_A_SADDR_S;
      OPD_ADD_A_ABS: nxt_cyc = nxt_long ? CYC_ADD_A_ABS_L
                                        : CYC_ADD_A_ABS_S;
      OPD_BRANCH_REL: nxt_cyc = CYC_BRANCH;
      OPD_SET_ABIT: nxt_cyc = CYC_SET_ABIT;
      OPD_SEL_BANK: nxt_cyc = CYC_SEL_BANK;
      default: nxt_cyc = CYC_RESTORE;
    endcase
    go = start && (state_ff == OPD_IDLE) && !refuse;
    commit = (state_ff == OPD_EXEC) && (cnt_ff == 4'h0);
  end

  // sequencer: one count per clk, op ends after its clock count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= OPD_IDLE;
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      long_ff <= 1'b0;
    end
    else
    begin
      done_ff <= commit;
      fault_ff <= start && (state_ff == OPD_IDLE) && refuse; // see (RQ22)
      case (state_ff)
        OPD_IDLE:
          if (go)
          begin
            state_ff <= OPD_EXEC;
            cnt_ff <= nxt_cyc - 4'h1; // see (RQ1)
            busy_ff <= 1'b1;
            long_ff <= nxt_long; // see (RQ3)
          end
        default:
          if (commit)
          begin
            state_ff <= OPD_IDLE;
            busy_ff <= 1'b0;
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
      endcase
    end
  end

  // results latched when an op is accepted
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_ff <= OPD_ADD_A_IMM;
      dst_ff <= 5'h00;
      res_ff <= 8'h00;
      cy_ff <= 1'b0;
      ac_ff <= 1'b0;
      z_ff <= 1'b0;
      target_ff <= 16'h0000;
      mem_waddr_ff <= 16'h0000;
    end
    else if (go)
    begin
      op_ff <= op;
      dst_ff <= (op == OPD_ADD_R_A) ? {bank, reg_sel} : {bank, REG_A};
      res_ff <= is_add ? sum : imm;
      if (op == OPD_SET_ABIT)
        res_ff <= cur_a | (8'h01 << bit_sel); // see (RQ13)
      cy_ff <= cout; // see (RQ18)
      ac_ff <= half;
      z_ff <= zero;
      mem_waddr_ff <= addr;
      if (op == OPD_BRANCH_REL)
        target_ff <= pc + {{8{disp[7]}}, disp}; // see (RQ12)
    end
  end

  // memory write back of the short direct add
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_ff <= 1'b0;
      mem_wdata_ff <= 8'h00;
    end
    else
    begin
      mem_wr_ff <= commit && (op_ff == OPD_ADD_SADDR_IMM); // see (RQ20)
      if (commit)
        mem_wdata_ff <= res_ff;
    end
  end

  // general registers, four banks of eight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 32; i++)
        regs_ff[i] <= REG_RST;
    end
    else if (commit && (op_ff != OPD_ADD_SADDR_IMM)
             && (op_ff != OPD_BRANCH_REL) && (op_ff != OPD_SEL_BANK)
             && (op_ff != OPD_RESTORE_FLAGS))
      regs_ff[dst_ff] <= res_ff; // see (RQ18)
  end

  // processor flags: computed, restored, or kept per op
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_ff <= FLAGS_RST;
    else
    begin
      if (commit && (op_ff == OPD_RESTORE_FLAGS))
        flags_ff <= res_ff; // see (RQ16)
      else if (commit && (op_ff == OPD_SEL_BANK))
      begin
        flags_ff[FLG_BANK_HI] <= res_ff[1]; // see (RQ14)
        flags_ff[FLG_BANK_LO] <= res_ff[0];
      end
      else if (commit && (op_ff != OPD_BRANCH_REL)
               && (op_ff != OPD_SET_ABIT))
      begin
        flags_ff[FLG_CY] <= cy_ff; // see (RQ16) (RQ19)
        flags_ff[FLG_AC] <= ac_ff; // see (RQ21)
        flags_ff[FLG_Z] <= z_ff; // see (RQ21)
      end
      // nmi entry wins over a return or restore in the same cycle
      if (nmi_take)
        flags_ff[FLG_NMI] <= 1'b1; // see (RQ15)
      else if (nmi_return)
        flags_ff[FLG_NMI] <= 1'b0;
    end
  end

  // registered views of accumulators, pair and address check
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff <= 8'h00;
      wacc_ff <= 16'h0000;
      pair_ff <= 16'h0000;
      addr_ok_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= cur_a; // see (RQ17)
      wacc_ff <= {cur_a, regs_ff[{bank, REG_X}]}; // see (RQ17)
      pair_ff <= {regs_ff[{bank, pair_sel, 1'b1}],
                  regs_ff[{bank, pair_sel, 1'b0}]}; // see (RQ5)
      addr_ok_ff <= addr_legal(amode, addr, sfr_word_ok);
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign fault = fault_ff;
  assign long_timing = long_ff;
  assign addr_ok = addr_ok_ff;
  assign mem_wr = mem_wr_ff;
  assign mem_waddr = mem_waddr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign branch_target = target_ff;
  assign acc = acc_ff;
  assign word_accumulator = wacc_ff;
  assign pair_value = pair_ff;
  assign processor_flags = flags_ff;
  assign carry_flag = flags_ff[FLG_CY];
  assign half_carry_flag = flags_ff[FLG_AC];
  assign zero_flag = flags_ff[FLG_Z];
  assign bank_select_field = {flags_ff[FLG_BANK_HI], flags_ff[FLG_BANK_LO]};
  assign irq_enable_flag = flags_ff[FLG_IE];
  assign nmi_in_service_flag = flags_ff[FLG_NMI];

  // timing, refusal, flag, branch target, address window and bank select checks
  a_imm_four_clk: assert property ( // see (RQ18)
    @(posedge clk) disable iff (!rst_n)
    (go && (op == OPD_ADD_A_IMM)) |=> busy_ff [*4] ##1 done_ff)
    else $error("add immediate did not take four clocks");
  a_saddr_long_clk: assert property ( // see (RQ20)
    @(posedge clk) disable iff (!rst_n)
    (go && (op == OPD_ADD_SADDR_IMM) && nxt_long) |-> ##9 mem_wr_ff)
    else $error("long short-direct add did not end after eight clocks");
  a_saddr_short_clk: assert property ( // see (RQ2)
    @(posedge clk) disable iff (!rst_n)
    (go && (op == OPD_ADD_SADDR_IMM) && !nxt_long) |-> ##7 mem_wr_ff)
    else $error("short short-direct add did not end after six clocks");
  a_abs_long_clk: assert property ( // see (RQ3)
    @(posedge clk) disable iff (!rst_n)
    (go && (op == OPD_ADD_A_ABS) && !in_hsram(addr))
      |=> !done_ff [*8] ##1 !done_ff ##1 done_ff)
    else $error("long absolute add did not take nine clocks");
  a_self_add_refused: assert property ( // see (RQ22)
    @(posedge clk) disable iff (!rst_n)
    (start && !busy_ff && (op == OPD_ADD_A_R) && (reg_sel == REG_A))
      |=> fault_ff && !busy_ff)
    else $error("add of A to itself was not refused");
  a_zero_result: assert property ( // see (RQ21)
    @(posedge clk) disable iff (!rst_n)
    (commit && (op_ff == OPD_ADD_A_IMM))
      |=> (zero_flag == (res_ff == 8'h00)) && (carry_flag == cy_ff))
    else $error("zero or carry flag does not match the sum");
  a_branch_target: assert property ( // see (RQ12)
    @(posedge clk) disable iff (!rst_n)
    (go && (op == OPD_BRANCH_REL))
      |=> target_ff == $past(pc) + {{8{$past(disp[7])}}, $past(disp)})
    else $error("branch target is not pc plus signed displacement");
  a_saddr_window: assert property ( // see (RQ6)
    @(posedge clk) disable iff (!rst_n)
    ((amode == OPD_AM_SADDR) && ((addr < SADDR_LO) || (addr > SADDR_HI)))
      |=> !addr_ok_ff)
    else $error("short direct address outside window accepted");
  a_bank_select: assert property ( // see (RQ14)
    @(posedge clk) disable iff (!rst_n)
    (commit && (op_ff == OPD_SEL_BANK)) |=> bank_select_field == res_ff[1:0])
    else $error("bank select field not loaded");

endmodule

// >>> dv/opd_mem_model.sv
// byte memory model answering the core's data bus
`timescale 1ns/1ps
module opd_mem_model
(
  input wire logic clk, // cpu clock
  input wire logic [15:0] addr, // read address
  input wire logic mem_wr, // write strobe
  input wire logic [15:0] mem_waddr, // write address
  input wire logic [7:0] mem_wdata, // write data
  output logic [7:0] mem_rdata // read data
);
  logic [7:0] mem_ff [256];

  // each byte starts as its own low address byte, so reads are predictable
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem_ff[i] = i[7:0];
  end

  // read answers at once; the core samples it with start
  assign mem_rdata = mem_ff[addr[7:0]];

  // strobed sums are written back on the clock edge
  always @(posedge clk)
  begin
    if (mem_wr === 1'b1)
      mem_ff[mem_waddr[7:0]] <= mem_wdata;
  end
endmodule

// >>> dv/cpu_operand_decode_add_path_tb.sv
// self-checking bench for the operand decode and add path
`timescale 1ns/1ps
module cpu_operand_decode_add_path_tb
  import opd_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  opd_op_e op = OPD_ADD_A_IMM;
  logic use_carry = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic [1:0] pair_sel = 2'h1;
  logic [7:0] imm = 8'h00;
  logic [15:0] addr = 16'h0000;
  opd_amode_e amode = OPD_AM_SADDR;
  logic sfr_word_ok = 1'b0;
  logic [7:0] disp = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic [2:0] bit_sel = 3'h0;
  logic nmi_take = 1'b0;
  logic nmi_return = 1'b0;
  logic [7:0] mem_rdata, mem_wdata, acc, processor_flags;
  logic busy, done, fault, long_timing, addr_ok, mem_wr;
  logic [15:0] mem_waddr, branch_target, word_accumulator, pair_value;
  logic carry_flag, half_carry_flag, zero_flag, irq_enable_flag;
  logic nmi_in_service_flag;
  logic [1:0] bank_select_field;
  int num_errors = 0;
  int cmp_count = 0;
  int nwr = 0;

  // 40 MHz cpu clock
  always #12.5 clk = ~clk;

  opd_core u_opd_core (
    .clk, .arst_n, .start, .op, .use_carry, .reg_sel, .pair_sel, .imm,
    .mem_rdata, .addr, .amode, .sfr_word_ok, .disp, .pc, .bit_sel,
    .nmi_take, .nmi_return, .busy, .done, .fault, .long_timing,
    .addr_ok, .mem_wr, .mem_waddr, .mem_wdata, .branch_target, .acc,
    .word_accumulator, .pair_value, .processor_flags, .carry_flag,
    .half_carry_flag, .zero_flag, .bank_select_field, .irq_enable_flag,
    .nmi_in_service_flag
  );

  opd_mem_model u_opd_mem_model (
    .clk, .addr, .mem_wr, .mem_waddr, .mem_wdata, .mem_rdata
  );

  // count write strobes toward the memory model
  always @(posedge clk)
  begin
    if (mem_wr === 1'b1)
      nwr++;
  end

  // print counts and verdict, then end the run
  task automatic stop_test();
  begin
    $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  // compare a design value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // compare a counted number of cycles or write strobes
  task automatic chk_n(input int got, input int exp);
  begin
    cmp_count++;
    if (got != exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task automatic note(input string s);
  begin
    $display("test done: %s", s);
  end
  endtask

  // issue one op, count busy cycles; ncyc of 0 means a refusal is expected
  task automatic run(input opd_op_e o, input logic [7:0] im,
    input logic [15:0] a, input logic [2:0] rs, input int ncyc);
    int n;
    int k;
  begin
    n = 0;
    op = o;
    imm = im;
    addr = a;
    reg_sel = rs;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (k = 0; k < 20 && done !== 1'b1 && fault !== 1'b1; k++)
    begin
      if (busy === 1'b1)
        n++;
      @(negedge clk);
    end
    if (k == 20)
    begin
      num_errors++;
      stop_test();
    end
    chk_n(n, ncyc);
    chk(fault, ncyc == 0);
    @(negedge clk);
  end
  endtask

  // check the address legality flag one cycle after the inputs
  task automatic tok(input opd_amode_e m, input logic [15:0] a,
    input logic w, input logic e);
  begin
    amode = m;
    addr = a;
    sfr_word_ok = w;
    @(negedge clk);
    chk(addr_ok, e);
  end
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(processor_flags, FLAGS_RST);
    chk(acc, REG_RST);
    run(OPD_ADD_A_IMM, 8'h0F, 16'h0000, 3'h0, 4);
    chk(acc, 8'h0F);
    run(OPD_ADD_A_IMM, 8'h01, 16'h0000, 3'h0, 4);
    chk(processor_flags, 8'h10);
    chk(half_carry_flag, 1'b1);
    run(OPD_ADD_A_IMM, 8'hF0, 16'h0000, 3'h0, 4);
    chk(processor_flags, 8'h41);
    chk(zero_flag, 1'b1);
    use_carry = 1'b1;
    run(OPD_ADD_A_IMM, 8'h00, 16'h0000, 3'h0, 4);
    use_carry = 1'b0;
    chk(acc, 8'h01);
    chk(processor_flags, 8'h00);
    note("accumulator adds");
    run(OPD_ADD_R_A, 8'h00, 16'h0000, 3'h2, 4);
    chk(pair_value, 16'h0001);
    run(OPD_ADD_R_A, 8'h00, 16'h0000, 3'h0, 4);
    chk(word_accumulator, 16'h0101);
    run(OPD_ADD_A_R, 8'h00, 16'h0000, 3'h2, 4);
    chk(acc, 8'h02);
    run(OPD_ADD_A_R, 8'h00, 16'h0000, REG_A, 0);
    chk(acc, 8'h02);
    note("register operands");
    run(OPD_ADD_SADDR_IMM, 8'h30, 16'hFE20, 3'h0, 6);
    chk(mem_wdata, 8'h50);
    chk(mem_waddr, 16'hFE20);
    chk(long_timing, 1'b0);
    run(OPD_ADD_SADDR_IMM, 8'hF0, 16'hFF10, 3'h0, 8);
    chk(mem_wdata, 8'h00);
    chk(processor_flags, 8'h41);
    chk(long_timing, 1'b1);
    run(OPD_ADD_SADDR_IMM, 8'h01, 16'hFE1F, 3'h0, 0);
    chk_n(nwr, 2);
    pc = 16'h1000;
    disp = 8'h80;
    run(OPD_BRANCH_REL, 8'h00, 16'h0000, 3'h0, CYC_BRANCH);
    chk(branch_target, 16'h0F80);
    chk(processor_flags, 8'h41);
    disp = 8'h7F;
    run(OPD_BRANCH_REL, 8'h00, 16'h0000, 3'h0, CYC_BRANCH);
    chk(branch_target, 16'h107F);
    note("memory forms and branch");
    run(OPD_ADD_A_SADDR, 8'h00, 16'hFE80, 3'h0, 4);
    chk(acc, 8'h82);
    run(OPD_ADD_A_SADDR, 8'h00, 16'hFF00, 3'h0, 5);
    run(OPD_ADD_A_ABS, 8'h00, 16'h1234, 3'h0, 9);
    chk(acc, 8'hB6);
    run(OPD_ADD_A_ABS, 8'h00, 16'hFB34, 3'h0, 8);
    chk(acc, 8'hEA);
    bit_sel = 3'h2;
    run(OPD_SET_ABIT, 8'h00, 16'h0000, 3'h0, CYC_SET_ABIT);
    chk(acc, 8'hEE);
    note("clock counts by area");
    run(OPD_SEL_BANK, 8'h03, 16'h0000, 3'h0, CYC_SEL_BANK);
    chk(bank_select_field, 2'h3);
    chk(processor_flags, 8'h28);
    chk(acc, REG_RST);
    run(OPD_SEL_BANK, 8'h00, 16'h0000, 3'h0, CYC_SEL_BANK);
    chk(acc, 8'hEE);
    nmi_take = 1'b1;
    @(negedge clk);
    nmi_take = 1'b0;
    chk(processor_flags, 8'h04);
    nmi_return = 1'b1;
    @(negedge clk);
    nmi_return = 1'b0;
    chk(nmi_in_service_flag, 1'b0);
    run(OPD_RESTORE_FLAGS, 8'h81, 16'h0000, 3'h0, CYC_RESTORE);
    chk(irq_enable_flag, 1'b1);
    chk(carry_flag, 1'b1);
    note("flags");
    tok(OPD_AM_SADDR, 16'hFE20, 1'b0, 1'b1);
    tok(OPD_AM_SADDR, 16'hFF20, 1'b0, 1'b0);
    tok(OPD_AM_SADDRP, 16'hFE21, 1'b0, 1'b0);
    tok(OPD_AM_SADDRP, 16'hFE22, 1'b0, 1'b1);
    tok(OPD_AM_SFR, 16'hFFD5, 1'b1, 1'b0);
    tok(OPD_AM_SFR, 16'hFF10, 1'b0, 1'b1);
    tok(OPD_AM_SFRP, 16'hFF10, 1'b0, 1'b0);
    tok(OPD_AM_SFRP, 16'hFF11, 1'b1, 1'b0);
    tok(OPD_AM_SFRP, 16'hFF10, 1'b1, 1'b1);
    tok(OPD_AM_ABS, 16'hFFFF, 1'b0, 1'b1);
    tok(OPD_AM_ABS_WORD, 16'h1235, 1'b0, 1'b0);
    tok(OPD_AM_ELEVEN, 16'h07FF, 1'b0, 1'b0);
    tok(OPD_AM_ELEVEN, 16'h0FFF, 1'b0, 1'b1);
    tok(OPD_AM_TABLE, 16'h0040, 1'b0, 1'b1);
    tok(OPD_AM_TABLE, 16'h0041, 1'b0, 1'b0);
    tok(OPD_AM_TABLE, 16'h0080, 1'b0, 1'b0);
    note("address ranges");
    stop_test();
  end
endmodule
